//--- src/rx_buffer_id_capture.sv
// design: identifier high and low bytes of the two receive buffers
`timescale 1ns/1ns

module rx_buffer_id_capture
  import rx_ident_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] load_buffer,
  input wire rx_ident_t load_ident,
  input wire logic read_strobe,
  input wire logic [7:0] read_addr,
  output logic [7:0] read_data,
  output logic read_hit
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] reset_sync;
  logic rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      reset_sync <= SYNC_RESET;
    else
      reset_sync <= {reset_sync[0], 1'b1};
  end

  assign rst_n = reset_sync[1];

  // ****************************************
  // address decode
  // ****************************************

  // decoded read address
  logic addr_mapped;
  logic addr_buffer;
  logic addr_low_byte;

  // which buffer and byte an address names; no writes exist, both bytes read-only
  always_comb
  begin
    addr_mapped = 1'b1;
    addr_buffer = 1'b0;
    addr_low_byte = 1'b0;
    unique case (read_addr)
      // buffer zero, high byte
      ADDR_RX0_STD_ID_HIGH:
      begin
        addr_buffer = 1'b0;
        addr_low_byte = 1'b0;
      end
      // buffer zero, low byte
      ADDR_RX0_STD_ID_LOW:
      begin
        addr_buffer = 1'b0;
        addr_low_byte = 1'b1;
      end
      // buffer one, high byte
      ADDR_RX1_STD_ID_HIGH:
      begin
        addr_buffer = 1'b1;
        addr_low_byte = 1'b0;
      end
      // buffer one, low byte
      ADDR_RX1_STD_ID_LOW:
      begin
        addr_buffer = 1'b1;
        addr_low_byte = 1'b1;
      end
      // any other address: no hit, zero data
      default:
      begin
        addr_mapped = 1'b0;
      end
    endcase
  end

  // ****************************************
  // identifier storage
  // ****************************************

  // stored fields of the last message loaded into each buffer
  logic [10:0] short_store [2];
  logic remote_store [2];
  logic ext_store [2];
  logic [1:0] long_store [2];

  // byte images and the byte a read picks, per buffer
  logic [7:0] id_high [2];
  logic [7:0] id_low [2];
  logic [7:0] buffer_byte [2];

  // one set of field registers and byte images per receive buffer
  for (genvar b = 0; b < 2; b++)
  begin : g_buf
    // ****************************************
    // field capture
    // ****************************************

    // short identifier; unknown after power-on, so never reset
    always_ff @(posedge sys_clk)
    begin
      if (load_buffer[b])
      begin
        short_store[b] <= load_ident.short_ident_field;
      end
    end

    // remote flag, kept as received even for an extended frame
    always_ff @(posedge sys_clk)
    begin
      if (load_buffer[b])
      begin
        remote_store[b] <= load_ident.short_frame_remote_flag;
      end
    end

    // extended-frame flag
    always_ff @(posedge sys_clk)
    begin
      if (load_buffer[b])
      begin
        ext_store[b] <= load_ident.extended_frame;
      end
    end

    // long identifier bits 17 and 16
    always_ff @(posedge sys_clk)
    begin
      if (load_buffer[b])
      begin
        long_store[b] <= load_ident.long_ident_field;
      end
    end

    // ****************************************
    // byte images
    // ****************************************

    // high byte: short identifier bits 10..3, bit 10 on top
    always_comb
    begin
      id_high[b] = short_store[b][10:3];
    end

    // low byte, field by field at the package positions
    always_comb
    begin
      id_low[b] = 8'h00; // bit 2 is never set
      id_low[b][LOW_SHORT_ID_LSB +: 3] = short_store[b][2:0];
      id_low[b][LOW_REMOTE_BIT] = remote_store[b];
      id_low[b][LOW_EXT_FLAG_BIT] = ext_store[b];
      id_low[b][LOW_LONG_ID_LSB +: 2] = long_store[b];
    end

    // byte of this buffer that the address names
    always_comb
    begin
      if (addr_low_byte)
        buffer_byte[b] = id_low[b];
      else
        buffer_byte[b] = id_high[b];
    end
  end

  // ****************************************
  // read data select
  // ****************************************

  // next values of the read answer
  logic [7:0] next_read_data;
  logic next_read_hit;

  // byte of the named buffer, or zero for an unmapped address
  always_comb
  begin
    if (addr_mapped)
    begin
      next_read_data = buffer_byte[addr_buffer];
    end
    else
    begin
      next_read_data = 8'h00;
    end
  end

  // hit only for a strobe on a mapped byte
  always_comb
  begin
    next_read_hit = read_strobe && addr_mapped;
  end

  // ****************************************
  // read answer registers
  // ****************************************

  // read data: taken on each strobe, held between strobes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      read_data <= READ_DATA_RESET;
    else if (read_strobe)
      read_data <= next_read_data;
  end

  // read hit: high in the cycle after each strobe cycle on a mapped byte
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      read_hit <= HIT_RESET;
    else
      read_hit <= next_read_hit;
  end

endmodule

//--- src/rx_ident_pkg.sv
// package: register offsets, field positions and stored-identifier record for the receive identifier bytes
package rx_ident_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_RX0_STD_ID_HIGH = 8'h61;
  localparam logic [7:0] ADDR_RX0_STD_ID_LOW = 8'h62;
  localparam logic [7:0] ADDR_RX1_STD_ID_HIGH = 8'h71;
  localparam logic [7:0] ADDR_RX1_STD_ID_LOW = 8'h72;

  // ****************************************
  // field positions in the identifier-low byte
  // ****************************************
  localparam int LOW_SHORT_ID_LSB = 5;
  localparam int LOW_REMOTE_BIT = 4;
  localparam int LOW_EXT_FLAG_BIT = 3;
  localparam int LOW_LONG_ID_LSB = 0;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic HIT_RESET = 1'b0;

  // identifier fields of an accepted message
  typedef struct packed {
    logic [10:0] short_ident_field;
    logic short_frame_remote_flag;
    logic extended_frame;
    logic [17:16] long_ident_field;
  } rx_ident_t;

endpackage

//--- verification/can_node.sv
// partner model: bus node storing accepted identifiers
`timescale 1ns/1ns
module can_node
  import rx_ident_pkg::*;
(input wire logic sys_clk, output logic [1:0] load_buffer = 2'h0, output rx_ident_t load_ident = 15'h0);
  // one-cycle store strobe, ident scrambled once released
  task send(input logic [1:0] b, input rx_ident_t id);
    @(negedge sys_clk) {load_buffer, load_ident} = {b, id};
    @(negedge sys_clk) {load_buffer, load_ident} = {2'h0, ~id};
  endtask
endmodule

//--- verification/rx_buffer_id_capture_tb.sv
// testbench: fills both buffers and reads the identifier bytes back
`timescale 1ns/1ns
module rx_buffer_id_capture_tb;
  import rx_ident_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, read_strobe = 1'b0, read_hit;
  logic [7:0] read_addr = 8'h00, read_data;
  logic [1:0] load_buffer;
  rx_ident_t load_ident;
  int fails = 0, check_count = 0, cycles = 0;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 200)
      report_and_stop(1);
  end
  can_node node(.sys_clk, .load_buffer, .load_ident);
  rx_buffer_id_capture dut(.sys_clk, .resetn, .load_buffer, .load_ident, .read_strobe, .read_addr, .read_data, .read_hit);
  task report_and_stop(input int late);
    fails += late;
    $display("fails %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // load, read one byte the next cycle, judge hit and data
  task probe(input logic [1:0] b, input rx_ident_t id, input logic [7:0] a, input logic [8:0] e);
    node.send(b, id);
    {read_strobe, read_addr} = {1'b1, a};
    @(negedge sys_clk) read_strobe = 1'b0;
    check_count++;
    if ({read_hit, read_data} !== e)
    begin
      fails++;
      $display("wrong value at %0t: address %h", $time, a);
    end
  endtask
  // standard remote frame in buffer zero
  task scen_std;
    probe(2'h1, 15'h5A5B, 8'h61, 9'h1B4);
    probe(2'h1, 15'h5A5B, 8'h62, 9'h1B3);
  endtask
  // extended frame in buffer one, buffer zero kept, unmapped byte zero
  task scen_ext;
    probe(2'h2, 15'h2C36, 8'h71, 9'h158);
    probe(2'h2, 15'h2C36, 8'h72, 9'h16A);
    probe(2'h0, 15'h0000, 8'h61, 9'h1B4);
    probe(2'h0, 15'h0000, 8'h63, 9'h000);
  endtask
  // standard data frame into both buffers at once
  task scen_both;
    probe(2'h3, 15'h1232, 8'h62, 9'h162);
    probe(2'h0, 15'h0000, 8'h71, 9'h124);
    probe(2'h0, 15'h0000, 8'h72, 9'h162);
  endtask
  // mid-run reset clears the answer and keeps the stored identifiers
  task scen_reset;
    @(negedge sys_clk) resetn = 1'b0;
    @(negedge sys_clk) check_count++;
    if ({read_hit, read_data} !== 9'h000)
    begin
      fails++;
      $display("wrong value at %0t: answer not cleared by reset", $time);
    end
    resetn = 1'b1;
    repeat (2) @(negedge sys_clk);
    probe(2'h0, 15'h0000, 8'h61, 9'h124);
  endtask
  initial
  begin
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (3) @(negedge sys_clk);
    scen_std;
    scen_ext;
    scen_both;
    scen_reset;
    report_and_stop(0);
  end
endmodule
bind rx_buffer_id_capture rx_id_sva chk(.sys_clk, .resetn, .load_buffer, .load_ident, .read_strobe, .read_addr,
  .read_data, .read_hit);

//--- verification/rx_id_sva.sv
// checker: identifier byte properties
`timescale 1ns/1ns
module rx_id_sva
  import rx_ident_pkg::*;
(input wire logic sys_clk, resetn, read_strobe, read_hit, input wire logic [1:0] load_buffer,
  input wire rx_ident_t load_ident, input wire logic [7:0] read_addr, read_data);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [1:0] lb;
  rx_ident_t p1, p2;
  wire r = read_strobe && read_addr inside {ADDR_RX0_STD_ID_HIGH, ADDR_RX0_STD_ID_LOW, ADDR_RX1_STD_ID_HIGH,
    ADDR_RX1_STD_ID_LOW};
  wire n = r && lb[read_addr[4]];
  // loads and ident from the edges before a read
  always_ff @(posedge sys_clk) {lb, p2, p1} <= {load_buffer, p1, load_ident};
  chk_hit_map: assert property (read_hit == $past(r)) else $error("bad hit");
  chk_miss_zero: assert property (read_strobe && !r |=> !read_data) else $error("bad miss");
  chk_idle_hold: assert property (!read_strobe |=> $stable(read_data)) else $error("data moved");
  chk_low_gap: assert property (r && read_addr[1] |=> !read_data[2]) else $error("bad gap");
  chk_ext_flag: assert property (n && read_addr[1] |=> read_data[3] == p2[2]) else $error("bad ext");
  chk_high_byte: assert property (n && !read_addr[1] |=> read_data == p2[14:7]) else $error("bad high");
  chk_low_byte:
    assert property (n && read_addr[1] |=> read_data[7:4] == p2[6:3] && read_data[1:0] == p2[1:0]) else $error("bad low");
endmodule
